/* File: rtl/cpf_pin_function_select.v */
/*
 * Top of the charger control pin function select block.
 * Assumes a byte-wide register port from the serial register interface,
 * pins synchronous to i_clock and analog status as plain levels.
 */
`include "cpf_defines.vh"
module cpf_pin_function_select #(
    parameter [3:0] OPT_CODE = `CPF_OPT_CODE_RESET
) (
    input wire i_clock,
    input wire i_resetn,
    input wire [7:0] i_reg_addr,
    input wire i_reg_write,
    input wire [7:0] i_reg_wdata,
    output reg [7:0] o_reg_rdata,
    input wire [3:0] i_option_code,
    input wire i_option_load,
    input wire i_pin_one_polarity,
    input wire i_control_pin_one,
    input wire i_control_pin_two,
    input wire i_control_pin_three,
    input wire i_interrupt_n,
    output reg o_control_pin_three,
    output reg o_control_pin_three_oe_n,
    input wire i_ldo_active,
    input wire i_sys_voltage_ok,
    input wire i_battery_node_ok,
    input wire i_battery_above_weak,
    input wire i_input_zero,
    input wire i_battery_monitor_enable,
    input wire i_charge_enable_reg,
    output reg o_system_power_good_flag,
    output reg o_iso_fet_disable,
    output reg [1:0] o_input_limit,
    output reg o_charge_enable,
    output reg o_recharge_disable,
    output reg o_fast_charge_half,
    output reg o_ldo_disable,
    output reg o_low_quiescent_mode,
    output reg o_code_reserved
);
    // ==========================================
    // Configuration state.
    reg [7:0] power_good_mode_select;
    reg [3:0] option_code;
    reg pin_one_polarity;
    wire [2:0] fn_one;
    wire [2:0] fn_two;
    wire [2:0] fn_three;
    wire irq_on_three;
    wire reserved;
    wire flag;
    wire iso_off;
    wire pin_one;
    reg [2:0] fn [0:2];
    reg [2:0] lvl;
    reg next_charge;
    reg next_limit_low;
    reg next_high_limit;
    reg next_recharge;
    reg next_half;
    reg next_ldo;
    reg next_quiescent;
    reg has_charge_pin;
    integer k;

    always @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            power_good_mode_select <= `CPF_MODE_REG_RESET;
            option_code <= `CPF_OPT_CODE_RESET;
            pin_one_polarity <= `CPF_POL_RESET;
        end
        else
        begin
            if (i_reg_write && i_reg_addr == `CPF_MODE_REG_ADDR)
                power_good_mode_select <= i_reg_wdata;
            if (i_option_load)
            begin
                option_code <= i_option_code;
                pin_one_polarity <= i_pin_one_polarity;
            end
        end
    end

    // ==========================================
    // Pin decode.
    assign pin_one = i_control_pin_one ^ pin_one_polarity;

    cpf_pin_map u_map (
        .i_code(option_code),
        .o_fn_one(fn_one),
        .o_fn_two(fn_two),
        .o_fn_three(fn_three),
        .o_irq_on_three(irq_on_three),
        .o_reserved(reserved)
    );

    always @*
    begin
        fn[0] = fn_one;
        fn[1] = fn_two;
        fn[2] = irq_on_three ? `CPF_FN_NONE : fn_three;
        lvl = {i_control_pin_three, i_control_pin_two, pin_one};
        next_charge = i_charge_enable_reg;
        has_charge_pin = 1'b0;
        next_limit_low = 1'b1;
        next_high_limit = 1'b0;
        next_recharge = 1'b0;
        next_half = 1'b0;
        next_ldo = 1'b0;
        next_quiescent = 1'b0;
        for (k = 0; k < 3; k = k + 1)
        begin
            case (fn[k])
                `CPF_FN_LIMIT: next_limit_low = !lvl[k];
                `CPF_FN_HIGH_LIMIT: next_high_limit = next_high_limit | lvl[k];
                `CPF_FN_CHARGE:
                begin
                    has_charge_pin = 1'b1;
                    next_charge = lvl[k];
                end
                `CPF_FN_RECHARGE: next_recharge = lvl[k];
                `CPF_FN_FAST_HALF: next_half = lvl[k];
                `CPF_FN_LDO: next_ldo = lvl[k];
                `CPF_FN_QUIESCENT: next_quiescent = lvl[k];
                default: ;
            endcase
        end
    end

    cpf_power_good u_pg (
        .i_mode(power_good_mode_select[1:0]),
        .i_ldo_active(i_ldo_active),
        .i_sys_voltage_ok(i_sys_voltage_ok),
        .i_battery_node_ok(i_battery_node_ok),
        .i_battery_above_weak(i_battery_above_weak),
        .i_input_zero(i_input_zero),
        .i_battery_monitor_enable(i_battery_monitor_enable),
        .i_charge_enabled(o_charge_enable),
        .o_flag(flag),
        .o_iso_fet_disable(iso_off)
    );

    // ==========================================
    // Registered outputs.
    always @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            o_reg_rdata <= 8'h00;
            o_control_pin_three <= 1'b1;
            o_control_pin_three_oe_n <= 1'b1;
            o_system_power_good_flag <= 1'b0;
            o_iso_fet_disable <= 1'b0;
            o_input_limit <= `CPF_ILIM_100;
            o_charge_enable <= 1'b0;
            o_recharge_disable <= 1'b0;
            o_fast_charge_half <= 1'b0;
            o_ldo_disable <= 1'b0;
            o_low_quiescent_mode <= 1'b0;
            o_code_reserved <= 1'b0;
        end
        else
        begin
            o_reg_rdata <= (i_reg_addr == `CPF_MODE_REG_ADDR) ? power_good_mode_select : 8'h00;
            o_control_pin_three <= i_interrupt_n;
            o_control_pin_three_oe_n <= !irq_on_three;
            o_system_power_good_flag <= flag;
            o_iso_fet_disable <= iso_off;
            if (next_high_limit)
                o_input_limit <= `CPF_ILIM_1500;
            else if (next_limit_low)
                o_input_limit <= `CPF_ILIM_100;
            else
                o_input_limit <= `CPF_ILIM_500;
            o_charge_enable <= has_charge_pin ? next_charge : i_charge_enable_reg;
            o_recharge_disable <= next_recharge;
            o_fast_charge_half <= next_half;
            o_ldo_disable <= next_ldo;
            o_low_quiescent_mode <= next_quiescent;
            o_code_reserved <= reserved;
        end
    end
endmodule // cpf_pin_function_select

/* File: inc/cpf_defines.vh */
/*
 * Constants for the charger control pin function select block.
 * Assumes inclusion by bare name from the rtl files.
 */
`ifndef CPF_DEFINES_VH
`define CPF_DEFINES_VH
`define CPF_MODE_REG_ADDR 8'h11
`define CPF_MODE_REG_RESET 8'h00
`define CPF_OPT_CODE_RESET 4'h5
`define CPF_POL_RESET 1'b0
`define CPF_MODE_LDO 2'h0
`define CPF_MODE_BATT 2'h1
`define CPF_MODE_WEAK 2'h2
`define CPF_MODE_MIXED 2'h3
`define CPF_FN_NONE 3'h0
`define CPF_FN_LIMIT 3'h1
`define CPF_FN_HIGH_LIMIT 3'h2
`define CPF_FN_CHARGE 3'h3
`define CPF_FN_RECHARGE 3'h4
`define CPF_FN_FAST_HALF 3'h5
`define CPF_FN_LDO 3'h6
`define CPF_FN_QUIESCENT 3'h7
`define CPF_ILIM_100 2'h0
`define CPF_ILIM_500 2'h1
`define CPF_ILIM_1500 2'h2
`endif

/* File: rtl/cpf_pin_map.v */
/*
 * Option code to pin function table.
 * Assumes a four bit option code; output is combinational.
 */
`include "cpf_defines.vh"
module cpf_pin_map (
    input wire [3:0] i_code,
    output reg [2:0] o_fn_one,
    output reg [2:0] o_fn_two,
    output reg [2:0] o_fn_three,
    output reg o_irq_on_three,
    output reg o_reserved
);
    // ==========================================
    // Table lookup.
    always @*
    begin
        o_fn_one = `CPF_FN_LIMIT;
        o_fn_two = `CPF_FN_HIGH_LIMIT;
        o_fn_three = `CPF_FN_NONE;
        o_irq_on_three = i_code[3];
        o_reserved = 1'b0;
        case (i_code)
            4'h0:
            begin
                o_fn_two = `CPF_FN_QUIESCENT;
                o_fn_three = `CPF_FN_CHARGE;
            end
            4'h2: o_fn_three = `CPF_FN_QUIESCENT;
            4'h3: o_fn_three = `CPF_FN_FAST_HALF;
            4'h4: o_fn_three = `CPF_FN_LDO;
            4'h5: o_fn_three = `CPF_FN_CHARGE;
            4'h6:
            begin
                o_fn_two = `CPF_FN_RECHARGE;
                o_fn_three = `CPF_FN_CHARGE;
            end
            4'h7:
            begin
                o_fn_one = `CPF_FN_CHARGE;
                o_fn_two = `CPF_FN_QUIESCENT;
                o_fn_three = `CPF_FN_RECHARGE;
            end
            4'h8: o_fn_two = `CPF_FN_HIGH_LIMIT;
            4'h9: o_fn_two = `CPF_FN_CHARGE;
            4'hA: o_fn_two = `CPF_FN_QUIESCENT;
            4'hB: o_fn_two = `CPF_FN_RECHARGE;
            4'hC: o_fn_two = `CPF_FN_FAST_HALF;
            4'hD: o_fn_two = `CPF_FN_LDO;
            4'hE:
            begin
                o_fn_one = `CPF_FN_HIGH_LIMIT;
                o_fn_two = `CPF_FN_CHARGE;
            end
            4'hF:
            begin
                o_fn_one = `CPF_FN_QUIESCENT;
                o_fn_two = `CPF_FN_CHARGE;
            end
            default:
            begin
                o_fn_one = `CPF_FN_NONE;
                o_fn_two = `CPF_FN_NONE;
                o_fn_three = `CPF_FN_NONE;
                o_reserved = 1'b1;
            end
        endcase
    end
endmodule // cpf_pin_map

/* File: rtl/cpf_power_good.v */
/*
 * Power good flag decoder for the four flag modes.
 * Assumes analog status levels synchronous to the clock.
 */
`include "cpf_defines.vh"
module cpf_power_good (
    input wire [1:0] i_mode,
    input wire i_ldo_active,
    input wire i_sys_voltage_ok,
    input wire i_battery_node_ok,
    input wire i_battery_above_weak,
    input wire i_input_zero,
    input wire i_battery_monitor_enable,
    input wire i_charge_enabled,
    output reg o_flag,
    output reg o_iso_fet_disable
);
    // ==========================================
    // Mode decode.
    always @*
    begin
        o_flag = 1'b0;
        o_iso_fet_disable = 1'b0;
        case (i_mode)
            `CPF_MODE_LDO: o_flag = i_ldo_active && i_sys_voltage_ok;
            `CPF_MODE_BATT: o_flag = i_battery_node_ok;
            `CPF_MODE_WEAK:
            begin
                if (i_input_zero && i_battery_monitor_enable)
                begin
                    o_flag = 1'b1;
                    o_iso_fet_disable = !i_battery_above_weak;
                end
            end
            `CPF_MODE_MIXED:
                o_flag = i_charge_enabled ? i_battery_above_weak : i_ldo_active;
            default: o_flag = 1'b0;
        endcase
    end
endmodule // cpf_power_good

/* File: test/cpf_chk.sv */
/* Assertions on the pin function select top ports.
   Bound to every instance of the top; sees its ports only. */
module cpf_chk (
    input wire i_clock,
    input wire i_resetn,
    input wire [7:0] i_reg_addr,
    input wire i_reg_write,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    input wire [3:0] i_option_code,
    input wire i_option_load,
    input wire i_pin_one_polarity,
    input wire i_control_pin_one,
    input wire i_control_pin_two,
    input wire i_interrupt_n,
    input wire o_control_pin_three,
    input wire o_control_pin_three_oe_n,
    input wire i_ldo_active,
    input wire i_sys_voltage_ok,
    input wire i_battery_node_ok,
    input wire i_battery_above_weak,
    input wire i_input_zero,
    input wire i_battery_monitor_enable,
    input wire o_system_power_good_flag,
    input wire o_iso_fet_disable,
    input wire [1:0] o_input_limit,
    input wire o_charge_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    // ====================
    // Shadow settings.
    reg [1:0] mode;
    reg [3:0] code;
    reg pol;
    always @(posedge i_clock)
    begin
        if (!i_resetn)
        begin
            mode <= 2'h0;
            code <= 4'h5;
            pol <= 1'b0;
        end
        else
        begin
            if (i_reg_write && i_reg_addr == 8'h11)
                mode <= i_reg_wdata[1:0];
            if (i_option_load)
            begin
                code <= i_option_code;
                pol <= i_pin_one_polarity;
            end
        end
    end
    wire p1 = i_control_pin_one ^ pol;
    // ====================
    // Properties.
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    sequence s_wr;
        i_reg_write && i_reg_addr == 8'h11;
    endsequence
    sequence s_hold;
        (i_reg_addr == 8'h11 && !i_reg_write) [*2];
    endsequence
    chk_mode_read_back: assert property (
        s_wr ##1 s_hold |-> o_reg_rdata == $past(i_reg_wdata, 2))
        else $error("mode register read back wrong");
    chk_unmapped_zero: assert property (
        (i_reg_addr != 8'h11) [*2] |-> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_flag_ldo: assert property (
        mode == 2'h0 |=> o_system_power_good_flag == $past(i_ldo_active && i_sys_voltage_ok))
        else $error("flag wrong in mode 0");
    chk_flag_batt: assert property (
        mode == 2'h1 |=> o_system_power_good_flag == $past(i_battery_node_ok))
        else $error("flag wrong in mode 1");
    chk_flag_weak: assert property (
        mode == 2'h2 |=> o_system_power_good_flag == $past(i_input_zero && i_battery_monitor_enable)
        && o_iso_fet_disable == $past(i_input_zero && i_battery_monitor_enable
        && !i_battery_above_weak))
        else $error("flag or fet wrong in mode 2");
    chk_flag_mixed: assert property (
        mode == 2'h3 && o_charge_enable |=> o_system_power_good_flag == $past(i_battery_above_weak))
        else $error("flag wrong in mode 3");
    chk_flag_mixed_ldo: assert property (
        mode == 2'h3 && !o_charge_enable |=> o_system_power_good_flag == $past(i_ldo_active))
        else $error("flag wrong in mode 3 with charging off");
    chk_default_limit: assert property (
        code == 4'h5 |=> o_input_limit == $past(i_control_pin_two ? 2'h2 : {1'b0, p1}))
        else $error("input limit wrong");
    chk_irq_pin_drive: assert property (
        code[3] |=> !o_control_pin_three_oe_n && o_control_pin_three == $past(i_interrupt_n))
        else $error("pin three not driving interrupt");
endmodule // cpf_chk
bind cpf_pin_function_select cpf_chk u_chk (.*);

/* File: test/cpf_host.sv */
/* Host controller model that drives the control pins.
   Assumes wanted levels change just after a clock edge. */
module cpf_host (
    input wire i_clock,
    input wire [2:0] i_want,
    input wire i_dev_three,
    input wire i_dev_three_oe_n,
    output logic o_one,
    output logic o_two,
    output wire o_three
);
    timeunit 1ns;
    timeprecision 100ps;
    logic host_three;
    initial {host_three, o_two, o_one} = 3'h0;
    always @(posedge i_clock)
    begin
        #1;
        {host_three, o_two, o_one} <= i_want;
    end
    // The device owns pin three while its enable is low.
    assign o_three = i_dev_three_oe_n ? host_three : i_dev_three;
endmodule // cpf_host

/* File: test/tb.sv */
/* Self-checking bench for the pin function select top.
   Host model drives the pins; the checker is bound to the top. */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, load = 1'b0, pol = 1'b0, intn = 1'b1;
    logic ldo = 1'b0, sys = 1'b0, node = 1'b0, above = 1'b0, zero = 1'b0, mon = 1'b0;
    logic chen = 1'b0;
    logic [7:0] addr = 8'h11, wdata = 8'h00;
    logic [3:0] code = 4'h5;
    logic [2:0] want = 3'h0;
    wire p1, p2, p3, p3o, oe_n, flag, fet, chg, rch, half, ldo_dis, lowq, res;
    wire [1:0] lim;
    wire [7:0] rdata;
    int error_cnt = 0, n_compared = 0, cycles = 0;
    logic [15:0] tbl [20] = '{16'h0202, 16'h5140, 16'h5280, 16'h5420, 16'h5840,
        16'h3408, 16'hC208, 16'h6210, 16'h7410, 16'h4404, 16'hD204, 16'hE180,
        16'h9220, 16'h2402, 16'h8280, 16'hA202, 16'hB210, 16'hF102, 16'hF802,
        16'h1001};
    cpf_pin_function_select u_dut (.i_clock(clk), .i_resetn(rstn), .i_reg_addr(addr),
        .i_reg_write(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_option_code(code),
        .i_option_load(load), .i_pin_one_polarity(pol), .i_control_pin_one(p1),
        .i_control_pin_two(p2), .i_control_pin_three(p3), .i_interrupt_n(intn),
        .o_control_pin_three(p3o), .o_control_pin_three_oe_n(oe_n), .i_ldo_active(ldo),
        .i_sys_voltage_ok(sys), .i_battery_node_ok(node), .i_battery_above_weak(above),
        .i_input_zero(zero), .i_battery_monitor_enable(mon), .i_charge_enable_reg(chen),
        .o_system_power_good_flag(flag), .o_iso_fet_disable(fet), .o_input_limit(lim),
        .o_charge_enable(chg), .o_recharge_disable(rch), .o_fast_charge_half(half),
        .o_ldo_disable(ldo_dis), .o_low_quiescent_mode(lowq), .o_code_reserved(res));
    cpf_host u_host (.i_clock(clk), .i_want(want), .i_dev_three(p3o),
        .i_dev_three_oe_n(oe_n), .o_one(p1), .o_two(p2), .o_three(p3));
    initial forever #2 clk = ~clk;
    // ====================
    // Shared tasks.
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            error_cnt++;
        end
    endtask
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
        step(2);
    endtask
    task automatic set_code(logic [3:0] c, logic p);
        code = c;
        pol = p;
        load = 1'b1;
        step(1);
        load = 1'b0;
        step(3);
    endtask
    task automatic flag_is(logic [1:0] exp);
        step(2);
        cmp("flag fet", {6'h00, exp}, {6'h00, flag, fet});
    endtask
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ====================
    // Scenarios.
    task automatic t_regs();
        cmp("reset outputs", 8'h01, {rdata[6:0], oe_n});
        wr_reg(8'h11, 8'hA6);
        cmp("mode reg", 8'hA6, rdata);
        addr = 8'h20;
        step(2);
        cmp("unmapped", 8'h00, rdata);
        wr_reg(8'h11, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_modes();
        ldo = 1'b1;
        sys = 1'b1;
        flag_is(2'b10);
        sys = 1'b0;
        flag_is(2'b00);
        wr_reg(8'h11, 8'h01);
        node = 1'b1;
        flag_is(2'b10);
        wr_reg(8'h11, 8'h02);
        zero = 1'b1;
        mon = 1'b1;
        flag_is(2'b11);
        above = 1'b1;
        flag_is(2'b10);
        mon = 1'b0;
        flag_is(2'b00);
        want = 3'b100;
        wr_reg(8'h11, 8'h03);
        flag_is(2'b10);
        above = 1'b0;
        flag_is(2'b00);
        want = 3'b000;
        step(2);
        flag_is(2'b10);
        $display("t_modes done");
    endtask
    task automatic t_pins();
        foreach (tbl[i])
        begin
            set_code(tbl[i][15:12], tbl[i][11]);
            want = tbl[i][10:8];
            step(4);
            cmp("pin roles", tbl[i][7:0], {lim, chg, rch, half, ldo_dis, lowq, res});
        end
        chen = 1'b1;
        set_code(4'h3, 1'b0);
        cmp("charge from register", 8'h01, {7'h00, chg});
        set_code(4'h5, 1'b0);
        cmp("charge from pin", 8'h00, {7'h00, chg});
        chen = 1'b0;
        set_code(4'h8, 1'b0);
        intn = 1'b0;
        step(3);
        cmp("pin three", 8'h00, {6'h00, oe_n, p3});
        intn = 1'b1;
        step(3);
        cmp("pin three", 8'h01, {6'h00, oe_n, p3});
        $display("t_pins done");
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial
    begin
        step(6);
        rstn = 1'b1;
        step(2);
        t_regs();
        t_modes();
        t_pins();
        report_and_stop();
    end
endmodule // tb
